/* File: spdif_in_pkg.sv */
`default_nettype none
package spdif_in_pkg;
  // serial word formats
  typedef enum logic [1:0] {
    fmt_left_just,
    fmt_i2s,
    fmt_right_just
  } fmt_t;
  // word width selections
  typedef enum logic [1:0] {
    width_16,
    width_18,
    width_20,
    width_24
  } width_sel_t;
  localparam int unsigned WORD_BITS     = 24;
  localparam int unsigned FIFO_DEPTH    = 8;
  localparam int unsigned SAMPLE_BITS   = WORD_BITS + 1;  // word plus channel flag
  localparam int unsigned HALF_SCLKS    = 32;             // 64 serial clocks per frame
  // msb delay after a frame sync edge in right-justified mode
  localparam logic [5:0] RJ_DELAY_16    = 6'h10;
  localparam logic [5:0] RJ_DELAY_18    = 6'h0e;
  localparam logic [5:0] RJ_DELAY_20    = 6'h0c;
  localparam logic [5:0] RJ_DELAY_24    = 6'h08;
  // word lengths
  localparam logic [4:0] LEN_16         = 5'h10;
  localparam logic [4:0] LEN_18         = 5'h12;
  localparam logic [4:0] LEN_20         = 5'h14;
  localparam logic [4:0] LEN_24         = 5'h18;
  // serial clock half period in sys_clk cycles (source side, 80 ns minimum period)
  localparam int unsigned SCLK_PERIOD_NS = 80;
  localparam int unsigned SYS_PERIOD_NS  = 25;
  localparam int unsigned SCLK_HALF_CYC  = (SCLK_PERIOD_NS + 2 * SYS_PERIOD_NS - 1)
                                           / (2 * SYS_PERIOD_NS);
  // oversampling clock ratios
  localparam logic [8:0] OSR_256        = 9'h100;
  localparam logic [8:0] OSR_384        = 9'h180;
  localparam logic [8:0] BIPHASE_PER_FS = 9'h080;  // 2 cells x 64 bits per frame
  localparam logic [23:0] WORD_RESET    = 24'h00_0000;
endpackage
`default_nettype wire

/* File: spdif_in_if.sv */
`default_nettype none
interface spdif_in_if;
  logic sclk;
  logic fsync;
  logic sdata;
  modport source (output sclk, output fsync, output sdata);
  modport sink   (input sclk, input fsync, input sdata);
endinterface
`default_nettype wire

/* File: spdif_fifo.sv */
`default_nettype none
module spdif_fifo #(
  parameter int unsigned WIDTH = 25,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             sys_clk,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output var  logic             in_ready,
  output var  logic [WIDTH-1:0] out_data,
  output var  logic             out_valid,
  input  wire logic             out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  // honest flags straight from the count
  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // storage
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // pointers and occupancy
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

/* File: spdif_in_source.sv */
`default_nettype none
module spdif_in_source (
  input  wire logic                      sys_clk,
  input  wire logic                      resetn,
  input  wire spdif_in_pkg::fmt_t        fmt,
  input  wire spdif_in_pkg::width_sel_t  width_sel,
  input  wire logic [23:0]               left_word,
  input  wire logic [23:0]               right_word,
  input  wire logic                      enable,
  output var  logic                      frame_start,
  spdif_in_if.source                     link
);
  logic [4:0]  half_cnt;
  logic [5:0]  bit_cnt;
  logic        sclk_r;
  logic        fs_r;
  logic        sd_r;
  logic [23:0] lat_l;
  logic [23:0] lat_r;
  logic [4:0]  len;
  logic [5:0]  first_bit;
  logic [5:0]  idx;
  logic [4:0]  pos;
  logic        chan;
  logic        next_bit;

  assign link.sclk  = sclk_r;
  assign link.fsync = fs_r;
  assign link.sdata = sd_r;

  always_comb begin
    case (width_sel)
      spdif_in_pkg::width_16: len = spdif_in_pkg::LEN_16;
      spdif_in_pkg::width_18: len = spdif_in_pkg::LEN_18;
      spdif_in_pkg::width_20: len = spdif_in_pkg::LEN_20;
      default:                len = spdif_in_pkg::LEN_24;
    endcase
  end

  // slot of the msb within each 32-clock half frame
  always_comb begin
    case (fmt)
      spdif_in_pkg::fmt_right_just: first_bit = 6'(6'd32 - {1'b0, len});
      spdif_in_pkg::fmt_i2s:        first_bit = 6'h01;
      default:                      first_bit = 6'h00;
    endcase
  end

  // bit position in the current half frame and channel; i2s fsync low is left
  assign chan = bit_cnt[5];
  always_comb begin
    idx      = 6'({1'b0, bit_cnt[4:0]} - first_bit);
    pos      = 5'(len - 5'h01 - idx[4:0]);
    next_bit = 1'b0;
    if (({1'b0, bit_cnt[4:0]} >= first_bit) && (idx < {1'b0, len})) begin
      next_bit = chan ? lat_r[pos] : lat_l[pos];
    end
  end

  // serial clock divider; data and fsync change on the falling edge
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      half_cnt    <= '0;
      sclk_r      <= 1'b0;
      bit_cnt     <= '0;
      fs_r        <= 1'b1;
      sd_r        <= 1'b0;
      lat_l       <= spdif_in_pkg::WORD_RESET;
      lat_r       <= spdif_in_pkg::WORD_RESET;
      frame_start <= 1'b0;
    end else begin
      frame_start <= 1'b0;
      if (!enable) begin
        half_cnt <= '0;
        sclk_r   <= 1'b0;
      end else if (half_cnt == 5'(spdif_in_pkg::SCLK_HALF_CYC - 1)) begin
        half_cnt <= '0;
        sclk_r   <= ~sclk_r;
        if (sclk_r) begin
          // falling edge: present the next bit so it is stable at the rise
          // valid at rise
          sd_r <= next_bit;
          fs_r <= (fmt == spdif_in_pkg::fmt_i2s) ? chan : ~chan;
          bit_cnt <= bit_cnt + 6'h01;
          if (bit_cnt == 6'h3f) begin
            lat_l       <= left_word;
            lat_r       <= right_word;
            frame_start <= 1'b1;
          end
        end
      end else begin
        half_cnt <= half_cnt + 5'h01;
      end
    end
  end
endmodule
`default_nettype wire

/* File: spdif_in_sink.sv */
`default_nettype none
module spdif_in_sink (
  input  wire logic                      sys_clk,
  input  wire logic                      resetn,
  input  wire spdif_in_pkg::fmt_t        fmt,
  input  wire spdif_in_pkg::width_sel_t  width_sel,
  input  wire logic                      osr_384,
  input  wire logic                      oversampling_clock_in,
  spdif_in_if.sink                       link,
  output var  logic [23:0]               sample_word,
  output var  logic                      sample_right,
  output var  logic                      sample_valid,
  input  wire logic                      sample_ready,
  output var  logic                      biphase_tick,
  output var  logic                      overrun
);
  typedef enum logic [1:0] {
    st_idle,
    st_wait,
    st_shift
  } rx_state_t;

  rx_state_t   state;
  logic [2:0]  sclk_sync;
  logic [1:0]  fs_sync;
  logic [1:0]  sd_sync;
  logic [1:0]  osc_sync;
  logic        fs_prev;
  logic        osc_prev;
  logic        rise;
  logic        fs_edge;
  logic [5:0]  delay_cnt;
  logic [4:0]  bits_left;
  logic [23:0] shift;
  logic        chan;
  logic [4:0]  len;
  logic [5:0]  start_delay;
  logic        push_valid;
  logic        push_ready;
  logic [24:0] push_data;
  logic [24:0] fifo_data;
  logic        fifo_valid;
  logic        fifo_pop;
  logic [8:0]  osc_cnt;
  logic [8:0]  osc_div;

  always_comb begin
    case (width_sel)
      spdif_in_pkg::width_16: len = spdif_in_pkg::LEN_16;
      spdif_in_pkg::width_18: len = spdif_in_pkg::LEN_18;
      spdif_in_pkg::width_20: len = spdif_in_pkg::LEN_20;
      default:                len = spdif_in_pkg::LEN_24;
    endcase
  end

  // clocks from fsync edge to msb, counted in rising sclk edges
  always_comb begin
    case (fmt)
      spdif_in_pkg::fmt_right_just: start_delay = 6'(6'd32 - {1'b0, len});
      spdif_in_pkg::fmt_i2s:        start_delay = 6'h01;
      default:                      start_delay = 6'h00;
    endcase
  end

  // pins cross into sys_clk through two flops before use
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sclk_sync <= '0;
      fs_sync   <= '0;
      sd_sync   <= '0;
      osc_sync  <= '0;
    end else begin
      sclk_sync <= {sclk_sync[1:0], link.sclk};
      fs_sync   <= {fs_sync[0], link.fsync};
      sd_sync   <= {sd_sync[0], link.sdata};
      osc_sync  <= {osc_sync[0], oversampling_clock_in};
    end
  end

  assign rise = sclk_sync[1] && !sclk_sync[2];
  assign fs_edge = rise && (fs_sync[1] != fs_prev);

  // frame sync history, updated only at sample points
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      // idle level of fsync, so no false edge follows reset
      fs_prev <= 1'b1;
    end else if (rise) begin
      fs_prev <= fs_sync[1];
    end
  end

  // word assembler
  // three formats
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state      <= st_idle;
      delay_cnt  <= '0;
      bits_left  <= '0;
      shift      <= spdif_in_pkg::WORD_RESET;
      chan       <= 1'b0;
      push_valid <= 1'b0;
      push_data  <= '0;
      overrun    <= 1'b0;
    end else begin
      if (push_valid && push_ready) begin
        push_valid <= 1'b0;
      end
      if (fs_edge) begin
        chan      <= (fmt == spdif_in_pkg::fmt_i2s) ? fs_sync[1] : !fs_sync[1];
        bits_left <= len;
        if (start_delay == 6'h00) begin
          shift <= {23'h00_0000, sd_sync[1]};
          bits_left <= 5'(len - 5'h01);
          state <= (len == 5'h01) ? st_idle : st_shift;
        end else begin
          delay_cnt <= 6'(start_delay - 6'h01);
          state     <= st_wait;
        end
      end else if (rise) begin
        case (state)
          st_wait: begin
            if (delay_cnt == 6'h00) begin
              shift     <= {23'h00_0000, sd_sync[1]};
              bits_left <= 5'(bits_left - 5'h01);
              state     <= st_shift;
            end else begin
              delay_cnt <= 6'(delay_cnt - 6'h01);
            end
          end
          st_shift: begin
            shift     <= {shift[22:0], sd_sync[1]};
            bits_left <= 5'(bits_left - 5'h01);
            if (bits_left == 5'h01) begin
              state <= st_idle;
              // full word in hand; drop it if the fifo still refuses
              if (push_valid && !push_ready) begin
                overrun <= 1'b1;
              end else begin
                push_valid <= 1'b1;
                push_data  <= {chan, 24'({shift[22:0], sd_sync[1]})};
              end
            end
          end
          default: state <= st_idle;
        endcase
      end
    end
  end

  spdif_fifo #(
    .WIDTH (spdif_in_pkg::SAMPLE_BITS),
    .DEPTH (spdif_in_pkg::FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .resetn    (resetn),
    .in_data   (push_data),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );

  // registered output stage; stalls on sample_ready back into the fifo
  assign fifo_pop = fifo_valid && (!sample_valid || sample_ready);
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sample_valid <= 1'b0;
      sample_word  <= spdif_in_pkg::WORD_RESET;
      sample_right <= 1'b0;
    end else if (fifo_pop) begin
      sample_valid <= 1'b1;
      sample_word  <= fifo_data[23:0];
      sample_right <= fifo_data[24];
    end else if (sample_ready) begin
      sample_valid <= 1'b0;
    end
  end

  // divide oversampling clock
  // ratio/128 edges per biphase cell; the sampled clock must stay under sys_clk/2
  assign osc_div = osr_384 ? 9'(spdif_in_pkg::OSR_384 / spdif_in_pkg::BIPHASE_PER_FS)
                           : 9'(spdif_in_pkg::OSR_256 / spdif_in_pkg::BIPHASE_PER_FS);
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      osc_prev     <= 1'b0;
      osc_cnt      <= '0;
      biphase_tick <= 1'b0;
    end else begin
      osc_prev     <= osc_sync[1];
      biphase_tick <= 1'b0;
      if (osc_sync[1] && !osc_prev) begin
        if (osc_cnt >= 9'(osc_div - 9'h001)) begin
          osc_cnt      <= '0;
          biphase_tick <= 1'b1;
        end else begin
          osc_cnt <= osc_cnt + 9'h001;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: spdif_in_checker.sv */
`default_nettype none
module spdif_in_checker (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic sclk,
  input wire logic fsync,
  input wire logic sdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       sclk_q;
  logic       fsync_q;
  logic       seen_edge;
  logic [6:0] rise_cnt;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // previous link levels for edge detection
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sclk_q  <= 1'b0;
      fsync_q <= 1'b1;
    end else begin
      sclk_q  <= sclk;
      fsync_q <= fsync;
    end
  end
  // sclk rises per half frame; the first edge is skipped, its count may be partial
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rise_cnt  <= 7'h00;
      seen_edge <= 1'b0;
    end else if (fsync != fsync_q) begin
      rise_cnt  <= 7'h00;
      seen_edge <= 1'b1;
    end else if (sclk && !sclk_q) begin
      rise_cnt <= rise_cnt + 7'h01;
    end
  end
  property p_steady_at_rise; $rose(sclk) |-> $stable(fsync) && $stable(sdata); endproperty
  a_steady_at_rise: assert property (p_steady_at_rise)
    else $error("link moved at sclk rise");
  property p_high_width; $rose(sclk) |=> sclk ##1 !sclk; endproperty
  a_high_width: assert property (p_high_width)
    else $error("sclk high width wrong");
  property p_low_width; $fell(sclk) |=> !sclk ##1 sclk; endproperty
  a_low_width: assert property (p_low_width)
    else $error("sclk low width wrong");
  property p_data_on_low; $changed(sdata) |-> !sclk; endproperty
  a_data_on_low: assert property (p_data_on_low)
    else $error("sdata moved while sclk high");
  property p_sync_on_fall; $changed(fsync) |-> !sclk ##1 !sclk; endproperty
  a_sync_on_fall: assert property (p_sync_on_fall)
    else $error("fsync moved off the fall");
  property p_half_frame; (fsync != fsync_q) && seen_edge |-> rise_cnt == 7'h20; endproperty
  a_half_frame: assert property (p_half_frame)
    else $error("half frame not 32 sclk");
  property p_sync_period; $changed(fsync) |-> ##128 $changed(fsync); endproperty
  a_sync_period: assert property (p_sync_period)
    else $error("fsync period wrong");
  property p_reset_idle; $rose(resetn) |-> !sclk && fsync && !sdata; endproperty
  a_reset_idle: assert property (p_reset_idle)
    else $error("link not idle after reset");
  c_sync_fall: cover property ($fell(fsync));
  c_sync_rise: cover property ($rose(fsync));
  c_one_bit: cover property ($rose(sclk) && sdata);
endmodule
`default_nettype wire

/* File: tb.sv */
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                     sys_clk      = 1'b0;
  logic                     resetn       = 1'b0;
  logic                     enable       = 1'b0;
  logic                     osr_384      = 1'b0;
  logic                     osc_clk      = 1'b0;
  logic                     sample_ready = 1'b0;
  logic                     checking     = 1'b0;
  logic                     synced       = 1'b0;
  logic [1:0]               ready_mode   = 2'h0;
  logic [23:0]              left_word    = 24'h00_0000;
  logic [23:0]              right_word   = 24'h00_0000;
  spdif_in_pkg::fmt_t       fmt          = spdif_in_pkg::fmt_left_just;
  spdif_in_pkg::width_sel_t width_sel    = spdif_in_pkg::width_16;
  logic                     frame_start;
  logic                     sample_right;
  logic                     sample_valid;
  logic                     biphase_tick;
  logic                     overrun;
  logic [23:0]              sample_word;
  logic [24:0]              exp_q[$];
  int                       err_count    = 0;
  int                       n_compared   = 0;
  int                       seed         = 95;
  int                       frames       = 0;
  int                       ticks        = 0;
  int                       edges        = 0;
  int                       n;
  spdif_in_if link ();
  spdif_in_source u_spdif_in_source (.sys_clk(sys_clk), .resetn(resetn), .fmt(fmt),
    .width_sel(width_sel), .left_word(left_word), .right_word(right_word), .enable(enable),
    .frame_start(frame_start), .link(link));
  spdif_in_sink u_spdif_in_sink (.sys_clk(sys_clk), .resetn(resetn), .fmt(fmt),
    .width_sel(width_sel), .osr_384(osr_384), .oversampling_clock_in(osc_clk), .link(link),
    .sample_word(sample_word), .sample_right(sample_right), .sample_valid(sample_valid),
    .sample_ready(sample_ready), .biphase_tick(biphase_tick), .overrun(overrun));
  spdif_in_checker u_spdif_in_checker (.sys_clk(sys_clk), .resetn(resetn), .sclk(link.sclk),
    .fsync(link.fsync), .sdata(link.sdata));
  // clocks; the oversampling period avoids lining up with sys_clk edges
  always #12.5 sys_clk = ~sys_clk;
  always #47 osc_clk = ~osc_clk;
  always @(posedge osc_clk) edges++;
  always @(posedge sys_clk) if (biphase_tick === 1'b1) ticks++;
  function automatic logic [23:0] mask_of(input spdif_in_pkg::width_sel_t w);
    case (w)
      spdif_in_pkg::width_16: mask_of = 24'h00_ffff;
      spdif_in_pkg::width_18: mask_of = 24'h03_ffff;
      spdif_in_pkg::width_20: mask_of = 24'h0f_ffff;
      default:                mask_of = 24'hff_ffff;
    endcase
  endfunction
  task automatic check_sample(input string what, input logic [24:0] exp, input logic [24:0] seen);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic check_count(input string what, input int exp, input int seen);
    n_compared++;
    if (seen != exp) begin
      err_count++;
      $display("ERROR %s expected %0d seen %0d", what, exp, seen);
    end
  endtask
  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // source words change once a frame; words of the first frame are not expected whole;
  // notes stop after four frames so the queue can drain before the next setup
  always @(negedge sys_clk) begin
    sample_ready <= (ready_mode == 2'h0) ? 1'($random(seed)) : (ready_mode == 2'h1);
    if (frame_start === 1'b1) begin
      if (checking && frames > 0 && frames < 5) begin
        exp_q.push_back({1'b0, left_word & mask_of(width_sel)});
        exp_q.push_back({1'b1, right_word & mask_of(width_sel)});
      end
      frames = frames + 1;
      left_word  <= 24'($random(seed));
      right_word <= 24'($random(seed));
    end
  end
  // results against the oldest note; stray right words before the first left are skipped
  always @(posedge sys_clk) begin
    if (checking && sample_valid === 1'b1 && sample_ready === 1'b1 && exp_q.size() > 0) begin
      if (synced || sample_right === 1'b0) begin
        synced = 1'b1;
        check_sample("sample", exp_q.pop_front(), {sample_right, sample_word});
      end
    end
  end
  task automatic restart(input spdif_in_pkg::fmt_t f, input spdif_in_pkg::width_sel_t w);
    resetn = 1'b0;
    fmt = f;
    width_sel = w;
    exp_q.delete();
    frames = 0;
    synced = 1'b0;
    repeat (3) @(negedge sys_clk);
    resetn = 1'b1;
  endtask
  task automatic wait_frames(input int cnt);
    for (int i = 0; i < 3000 && frames < cnt; i++) @(negedge sys_clk);
    check_count("frames", cnt, frames);
  endtask
  initial begin
    enable = 1'b1;
    // every format with every width
    for (int f = 0; f < 3; f++) begin
      for (int w = 0; w < 4; w++) begin
        restart(spdif_in_pkg::fmt_t'(f), spdif_in_pkg::width_sel_t'(w));
        checking = 1'b1;
        wait_frames(6);
        for (int i = 0; i < 40 && exp_q.size() > 0; i++) @(negedge sys_clk);
        checking = 1'b0;
        check_count("words left", 0, exp_q.size());
      end
    end
    // stall the reader until words are dropped
    ready_mode = 2'h2;
    restart(spdif_in_pkg::fmt_left_just, spdif_in_pkg::width_16);
    wait_frames(4);
    check_sample("overrun early", 25'h000_0000, {24'h00_0000, overrun});
    wait_frames(7);
    check_sample("overrun late", 25'h000_0001, {24'h00_0000, overrun});
    ready_mode = 2'h1;
    n = 0;
    // count handshakes: output stage, full fifo and one pending word
    repeat (30) begin
      @(posedge sys_clk);
      if (sample_valid === 1'b1 && sample_ready === 1'b1) n++;
    end
    @(negedge sys_clk);
    check_count("drained", spdif_in_pkg::FIFO_DEPTH + 2, n);
    // biphase tick per 2 or 3 oversampling edges
    for (int r = 0; r < 2; r++) begin
      osr_384 = r[0];
      repeat (20) @(negedge sys_clk);
      ticks = 0;
      edges = 0;
      repeat (1200) @(negedge sys_clk);
      n = ticks * (2 + r) - edges;
      check_count("biphase", 1, int'(n <= 6 && n >= -6));
    end
    print_verdict();
  end
  initial begin
    #(25 * 60000);
    err_count++;
    print_verdict();
  end
endmodule
`default_nettype wire
